// [hw/dit_pkg.sv]
package dit_pkg;

    // bus geometry: byte address is four times the register index
    localparam int unsigned DIT_ADDR_W = 18;
    localparam int unsigned DIT_IDX_W  = 16;
    localparam int unsigned DIT_PRE_W  = 6;

    // register indices
    localparam logic [15:0] DIT_CTRL_IDX          = 16'hfe3c;
    localparam logic [15:0] DIT_FIRST_PERIOD_IDX  = 16'hfe3e;
    localparam logic [15:0] DIT_SECOND_PERIOD_IDX = 16'hfe3f;
    localparam logic [15:0] DIT_FIRST_COUNT_IDX   = 16'hfe40;
    localparam logic [15:0] DIT_SECOND_COUNT_IDX  = 16'hfe41;

    // values after reset
    localparam logic [7:0] DIT_CTRL_RST   = 8'h00;
    localparam logic [7:0] DIT_PERIOD_RST = 8'h00;

    // control register field positions
    localparam int unsigned DIT_SECOND_SEL_LSB  = 6;
    localparam int unsigned DIT_FIRST_SEL_LSB   = 4;
    localparam int unsigned DIT_SECOND_FLAG_BIT = 3;
    localparam int unsigned DIT_SECOND_EN_BIT   = 2;
    localparam int unsigned DIT_FIRST_FLAG_BIT  = 1;
    localparam int unsigned DIT_FIRST_EN_BIT    = 0;

    // prescaler masks: tick when the low bits are all ones
    localparam logic [5:0] DIT_MASK_DIV4  = 6'h03;
    localparam logic [5:0] DIT_MASK_DIV16 = 6'h0f;
    localparam logic [5:0] DIT_MASK_DIV64 = 6'h3f;

    localparam logic [1:0] DIT_RESP_OKAY   = 2'h0;
    localparam logic [1:0] DIT_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DIT_SEL_STOP  = 2'b00,
        DIT_SEL_DIV4  = 2'b01,
        DIT_SEL_DIV16 = 2'b10,
        DIT_SEL_DIV64 = 2'b11
    } dit_clk_sel_type;

    typedef enum logic [2:0] {
        DIT_REG_NONE   = 3'b000,
        DIT_REG_CTRL   = 3'b001,
        DIT_REG_PER1   = 3'b010,
        DIT_REG_PER2   = 3'b011,
        DIT_REG_CNT1   = 3'b100,
        DIT_REG_CNT2   = 3'b101
    } dit_reg_type;

    function automatic logic [5:0] dit_tick_mask(input dit_clk_sel_type sel);
        case (sel)
            DIT_SEL_DIV4:  dit_tick_mask = DIT_MASK_DIV4;
            DIT_SEL_DIV16: dit_tick_mask = DIT_MASK_DIV16;
            default:       dit_tick_mask = DIT_MASK_DIV64;
        endcase
    endfunction

    function automatic dit_reg_type dit_decode(
        input logic [DIT_ADDR_W-1:0] addr);
        logic [DIT_IDX_W-1:0] idx;
        idx = addr[DIT_ADDR_W-1:2];
        case (idx)
            DIT_CTRL_IDX:          dit_decode = DIT_REG_CTRL;
            DIT_FIRST_PERIOD_IDX:  dit_decode = DIT_REG_PER1;
            DIT_SECOND_PERIOD_IDX: dit_decode = DIT_REG_PER2;
            DIT_FIRST_COUNT_IDX:   dit_decode = DIT_REG_CNT1;
            DIT_SECOND_COUNT_IDX:  dit_decode = DIT_REG_CNT2;
            default:               dit_decode = DIT_REG_NONE;
        endcase
    endfunction

endpackage

// [hw/dit_timer.sv]
`timescale 1ns/1ns
module dit_timer #(
    parameter int unsigned COUNT_W = 8
) (
    // clock and synchronised reset
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    // control
    input  wire dit_pkg::dit_clk_sel_type       clk_sel,
    input  wire logic [COUNT_W-1:0]             period,
    input  wire logic                           restart,
    // state
    output logic      [COUNT_W-1:0]             count_q,
    output logic      [dit_pkg::DIT_PRE_W-1:0]  pre_q,
    output logic                                overflow
);
    import dit_pkg::*;

    logic                 running;
    logic                 tick;
    logic [COUNT_W-1:0]   count_d;
    logic [DIT_PRE_W-1:0] pre_d;

    always_comb begin
        running  = (clk_sel != DIT_SEL_STOP);
        tick     = running && !restart &&
                   ((pre_q & dit_tick_mask(clk_sel)) ==
                    dit_tick_mask(clk_sel));
        overflow = tick && (count_q == period);
        if (!running || restart) begin
            pre_d   = '0;
            count_d = '0;
        end else begin
            pre_d   = pre_q + 1'b1;
            if (overflow) begin
                count_d = '0;
            end else if (tick) begin
                count_d = count_q + 1'b1;
            end else begin
                count_d = count_q;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q   <= '0;
            count_q <= '0;
        end else begin
            pre_q   <= pre_d;
            count_q <= count_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_stop_holds_zero:
    assert property (clk_sel == DIT_SEL_STOP |=> count_q == '0)
        else $error("stopped timer counter not zero");

    a_wrap_to_zero:
    assert property (overflow |=> count_q == '0 && pre_q[1:0] == 2'b00)
        else $error("counter did not wrap to zero at period");

    a_restart_clear:
    assert property (restart |=> pre_q == '0 && count_q == '0)
        else $error("period write did not clear prescaler and counter");

    a_tick_on_edge:
    assert property ($changed(count_q) |-> pre_q[1:0] == 2'b00)
        else $error("counter moved off a prescaler boundary");

    a_div4_gap:
    assert property (($changed(count_q) && clk_sel == DIT_SEL_DIV4)
                     ##1 (clk_sel == DIT_SEL_DIV4 && !restart)[*3]
                     |-> $stable(count_q))
        else $error("divide-by-4 tick came early");

endmodule

// [hw/dit_top.sv]
`timescale 1ns/1ns
// Summary of operation
// - each timer: 8-bit counter ticked by 6-bit prescaler
// - two timers fully independent of each other
// - select 00 reset, 01/10/11 tick 4/16/64
// - select 00 keeps counter at zero
// - match then next tick wraps, sets flag
// - period registers are 8-bit read/write
// - period write while running restarts prescaler, counter
// - flag set each period, only software clears
// - interrupt when any flag and enable both set
// - control bits: sel2, sel1, flag2, en2, flag1, en1
module dit_top #(
    parameter int unsigned COUNT_W = 8
) (
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           rst_n,
    // write address channel
    input  wire logic                           s_axi_awvalid,
    output logic                                s_axi_awready,
    input  wire logic [dit_pkg::DIT_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                     s_axi_awprot,
    // write data channel
    input  wire logic                           s_axi_wvalid,
    output logic                                s_axi_wready,
    input  wire logic [31:0]                    s_axi_wdata,
    input  wire logic [3:0]                     s_axi_wstrb,
    // write response channel
    output logic                                s_axi_bvalid,
    input  wire logic                           s_axi_bready,
    output logic      [1:0]                     s_axi_bresp,
    // read address channel
    input  wire logic                           s_axi_arvalid,
    output logic                                s_axi_arready,
    input  wire logic [dit_pkg::DIT_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                     s_axi_arprot,
    // read data channel
    output logic                                s_axi_rvalid,
    input  wire logic                           s_axi_rready,
    output logic      [31:0]                    s_axi_rdata,
    output logic      [1:0]                     s_axi_rresp,
    // shared interrupt request
    output logic                                timer_irq
);
    import dit_pkg::*;

    // reset release
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // bus slave state
    logic                  aw_got_q;
    logic                  aw_got_d;
    logic [DIT_ADDR_W-1:0] awaddr_q;
    logic [DIT_ADDR_W-1:0] awaddr_d;
    logic                  w_got_q;
    logic                  w_got_d;
    logic [7:0]            wbyte_q;
    logic [7:0]            wbyte_d;
    logic                  wlane_q;
    logic                  wlane_d;
    logic                  bvalid_q;
    logic                  bvalid_d;
    logic [1:0]            bresp_q;
    logic [1:0]            bresp_d;
    logic                  rvalid_q;
    logic                  rvalid_d;
    logic [31:0]           rdata_q;
    logic [31:0]           rdata_d;
    logic [1:0]            rresp_q;
    logic [1:0]            rresp_d;

    // register write strobe
    logic                  aw_hs;
    logic                  w_hs;
    logic                  wr_fire;
    logic                  wr_en;
    logic [DIT_ADDR_W-1:0] wr_addr;
    logic [7:0]            wr_byte;
    logic                  wr_lane;
    dit_reg_type           wr_reg;
    dit_reg_type           rd_reg;

    // timer registers
    dit_clk_sel_type       sel_q [2];
    dit_clk_sel_type       sel_d [2];
    logic [1:0]            flag_q;
    logic [1:0]            flag_d;
    logic [1:0]            en_q;
    logic [1:0]            en_d;
    logic [COUNT_W-1:0]    period_q [2];
    logic [COUNT_W-1:0]    period_d [2];
    logic [COUNT_W-1:0]    count [2];
    logic [1:0]            overflow;
    logic [1:0]            restart;
    logic                  ctrl_wr;

    function automatic logic [7:0] ctrl_byte(
        input dit_clk_sel_type s1,
        input dit_clk_sel_type s0,
        input logic [1:0]      fl,
        input logic [1:0]      en);
        ctrl_byte = '0;
        ctrl_byte[DIT_SECOND_SEL_LSB +: 2] = s1;
        ctrl_byte[DIT_FIRST_SEL_LSB +: 2]  = s0;
        ctrl_byte[DIT_SECOND_FLAG_BIT]     = fl[1];
        ctrl_byte[DIT_SECOND_EN_BIT]       = en[1];
        ctrl_byte[DIT_FIRST_FLAG_BIT]      = fl[0];
        ctrl_byte[DIT_FIRST_EN_BIT]        = en[0];
    endfunction

    // bus handshakes
    always_comb begin
        s_axi_awready = !aw_got_q && !bvalid_q;
        s_axi_wready  = !w_got_q && !bvalid_q;
        s_axi_arready = !rvalid_q;
        aw_hs   = s_axi_awvalid && s_axi_awready;
        w_hs    = s_axi_wvalid && s_axi_wready;
        wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr;
        wr_byte = w_got_q ? wbyte_q : s_axi_wdata[7:0];
        wr_lane = w_got_q ? wlane_q : s_axi_wstrb[0];
        wr_fire = (aw_got_q || aw_hs) && (w_got_q || w_hs) && !bvalid_q;
        wr_reg  = dit_decode(wr_addr);
        wr_en   = wr_fire && wr_lane;
        rd_reg  = dit_decode(s_axi_araddr);
    end

    always_comb begin
        aw_got_d = aw_got_q;
        awaddr_d = awaddr_q;
        w_got_d  = w_got_q;
        wbyte_d  = wbyte_q;
        wlane_d  = wlane_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        if (aw_hs) begin
            aw_got_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (w_hs) begin
            w_got_d = 1'b1;
            wbyte_d = s_axi_wdata[7:0];
            wlane_d = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = (wr_reg == DIT_REG_NONE) ? DIT_RESP_SLVERR
                                                : DIT_RESP_OKAY;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    // read path
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = DIT_RESP_OKAY;
            case (rd_reg)
                DIT_REG_CTRL: rdata_d = {24'h0,
                    ctrl_byte(sel_q[1], sel_q[0], flag_q, en_q)};
                DIT_REG_PER1: rdata_d = 32'(period_q[0]);
                DIT_REG_PER2: rdata_d = 32'(period_q[1]);
                DIT_REG_CNT1: rdata_d = 32'(count[0]);
                DIT_REG_CNT2: rdata_d = 32'(count[1]);
                default: begin
                    rdata_d = 32'h0;
                    rresp_d = DIT_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            aw_got_q <= 1'b0;
            awaddr_q <= '0;
            w_got_q  <= 1'b0;
            wbyte_q  <= 8'h00;
            wlane_q  <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q  <= DIT_RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= DIT_RESP_OKAY;
        end else begin
            aw_got_q <= aw_got_d;
            awaddr_q <= awaddr_d;
            w_got_q  <= w_got_d;
            wbyte_q  <= wbyte_d;
            wlane_q  <= wlane_d;
            bvalid_q <= bvalid_d;
            bresp_q  <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    // timer control registers
    always_comb begin
        ctrl_wr     = wr_en && (wr_reg == DIT_REG_CTRL);
        sel_d       = sel_q;
        en_d        = en_q;
        period_d    = period_q;
        restart[0]  = wr_en && (wr_reg == DIT_REG_PER1);
        restart[1]  = wr_en && (wr_reg == DIT_REG_PER2);
        if (ctrl_wr) begin
            sel_d[1] = dit_clk_sel_type'(wr_byte[DIT_SECOND_SEL_LSB +: 2]);
            sel_d[0] = dit_clk_sel_type'(wr_byte[DIT_FIRST_SEL_LSB +: 2]);
            en_d[1]  = wr_byte[DIT_SECOND_EN_BIT];
            en_d[0]  = wr_byte[DIT_FIRST_EN_BIT];
        end
        if (restart[0]) begin
            period_d[0] = wr_byte[COUNT_W-1:0];
        end
        if (restart[1]) begin
            period_d[1] = wr_byte[COUNT_W-1:0];
        end
        // overflow set wins over a clearing write
        flag_d[0] = overflow[0] ||
            (ctrl_wr ? wr_byte[DIT_FIRST_FLAG_BIT] : flag_q[0]);
        flag_d[1] = overflow[1] ||
            (ctrl_wr ? wr_byte[DIT_SECOND_FLAG_BIT] : flag_q[1]);
        timer_irq = |(flag_q & en_q);
    end

    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            sel_q[1]    <= dit_clk_sel_type'(
                DIT_CTRL_RST[DIT_SECOND_SEL_LSB +: 2]);
            sel_q[0]    <= dit_clk_sel_type'(
                DIT_CTRL_RST[DIT_FIRST_SEL_LSB +: 2]);
            flag_q      <= {DIT_CTRL_RST[DIT_SECOND_FLAG_BIT],
                            DIT_CTRL_RST[DIT_FIRST_FLAG_BIT]};
            en_q        <= {DIT_CTRL_RST[DIT_SECOND_EN_BIT],
                            DIT_CTRL_RST[DIT_FIRST_EN_BIT]};
            period_q[0] <= DIT_PERIOD_RST[COUNT_W-1:0];
            period_q[1] <= DIT_PERIOD_RST[COUNT_W-1:0];
        end else begin
            sel_q    <= sel_d;
            flag_q   <= flag_d;
            en_q     <= en_d;
            period_q <= period_d;
        end
    end

    // one counter pair per timer, nothing shared
    for (genvar i = 0; i < 2; i++) begin : g_timer
        dit_timer #(
            .COUNT_W (COUNT_W)
        ) u_timer (
            .clk      (clk),
            .rst_n    (rst_sync_q),
            .clk_sel  (sel_q[i]),
            .period   (period_q[i]),
            .restart  (restart[i]),
            .count_q  (count[i]),
            .pre_q    (),
            .overflow (overflow[i])
        );
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_q);

    a_flag_on_wrap:
    assert property (overflow[0] |=> flag_q[0] ##1
                     (flag_q[0] || $past(ctrl_wr)))
        else $error("first flag not set after wrap");

    a_second_flag_wrap:
    assert property (overflow[1] |=> flag_q[1])
        else $error("second flag not set after wrap");

    a_first_sticky:
    assert property (flag_q[0] && !ctrl_wr |=> flag_q[0])
        else $error("first flag cleared without a write");

    a_first_set_wins:
    assert property (overflow[0] && ctrl_wr && !wr_byte[DIT_FIRST_FLAG_BIT]
                     |=> flag_q[0])
        else $error("clearing write lost a first overflow");

    a_flag_sticky:
    assert property (flag_q[1] && !ctrl_wr |=> flag_q[1])
        else $error("second flag cleared without a write");

    a_set_wins:
    assert property (overflow[1] && ctrl_wr && !wr_byte[DIT_SECOND_FLAG_BIT]
                     |=> flag_q[1])
        else $error("clearing write lost an overflow");

    a_irq_request:
    assert property ((flag_q[0] && en_q[0]) || (flag_q[1] && en_q[1])
                     |-> timer_irq)
        else $error("interrupt missing for enabled flag");

    a_irq_quiet:
    assert property (!(|(flag_q & en_q)) |-> !timer_irq)
        else $error("interrupt without enabled flag");

    a_period_store:
    assert property (restart[0] |=> period_q[0] == $past(wr_byte))
        else $error("first period not stored");

    a_second_period:
    assert property (restart[1] |=> period_q[1] == $past(wr_byte))
        else $error("second period not stored");

    a_ctrl_readback:
    assert property (s_axi_arvalid && s_axi_arready && rd_reg == DIT_REG_CTRL
                     |=> rdata_q[1:0] == {$past(flag_q[0]), $past(en_q[0])})
        else $error("control readback misplaced");

    a_bvalid_hold:
    assert property (bvalid_q && !s_axi_bready |=> bvalid_q)
        else $error("write response dropped early");

    a_rvalid_hold:
    assert property (rvalid_q && !s_axi_rready |=> rvalid_q)
        else $error("read data dropped early");

endmodule

// [sim/dit_top_test.sv]
`timescale 1ns/1ns
module dit_top_test;
    import dit_pkg::*;

    // bus drive and design outputs
    logic                  clk;
    logic                  rst_n;
    logic                  awvalid, wvalid, bready, arvalid, rready;
    logic [DIT_ADDR_W-1:0] awaddr, araddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    wire logic             awready, wready, bvalid, arready, rvalid;
    wire logic             timer_irq;
    wire logic [1:0]       bresp, rresp;
    wire logic [31:0]      rdata;
    int                    errors;
    int                    total_checks;
    time                   t_take;

    dit_top u_dut (
        .clk           (clk),
        .rst_n         (rst_n),
        .s_axi_awvalid (awvalid),
        .s_axi_awready (awready),
        .s_axi_awaddr  (awaddr),
        .s_axi_awprot  (3'h0),
        .s_axi_wvalid  (wvalid),
        .s_axi_wready  (wready),
        .s_axi_wdata   (wdata),
        .s_axi_wstrb   (wstrb),
        .s_axi_bvalid  (bvalid),
        .s_axi_bready  (bready),
        .s_axi_bresp   (bresp),
        .s_axi_arvalid (arvalid),
        .s_axi_arready (arready),
        .s_axi_araddr  (araddr),
        .s_axi_arprot  (3'h0),
        .s_axi_rvalid  (rvalid),
        .s_axi_rready  (rready),
        .s_axi_rdata   (rdata),
        .s_axi_rresp   (rresp),
        .timer_irq     (timer_irq)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_up;
        errors++;
        $display("MISMATCH wait expected answer seen timeout");
        close_out();
    endtask

    // called just after a rising edge; t_take marks the write edge
    task automatic bus_write(input logic [15:0] idx, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        int   n;
        logic a_ok;
        logic w_ok;
        a_ok = 1'b0;
        w_ok = 1'b0;
        n = 0;
        awvalid <= 1'b1;
        awaddr  <= {idx, 2'b00};
        wvalid  <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        bready  <= 1'b1;
        while (!(a_ok && w_ok)) begin
            @(posedge clk);
            n++;
            if (n > 50) give_up();
            if (!a_ok && awready === 1'b1) begin
                a_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        t_take = $time;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 50) give_up();
        end while (bvalid !== 1'b1);
        r = bresp;
    endtask

    task automatic bus_read(input logic [15:0] idx, output logic [31:0] d,
                            output logic [1:0] r);
        int n;
        n = 0;
        arvalid <= 1'b1;
        araddr  <= {idx, 2'b00};
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (n > 50) give_up();
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(posedge clk);
            n++;
            if (n > 100) give_up();
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [1:0] r;
        bus_write(idx, d, 4'hf, r);
        check("bresp", 32'(DIT_RESP_OKAY), 32'(r));
    endtask

    task automatic rd_check(input string name, input logic [15:0] idx,
                            input logic [31:0] exp, input logic [1:0] rexp);
        logic [31:0] d;
        logic [1:0]  r;
        bus_read(idx, d, r);
        check(name, exp, d);
        check("rresp", 32'(rexp), 32'(r));
    endtask

    // period in cycles: (period value + 1) times 4, 16 or 64
    function automatic int exp_period(input int sel, input int p);
        exp_period = (4 ** sel) * (p + 1);
    endfunction

    // one timer running, the other stopped
    task automatic run_timer(input int t, input int sel, input int p);
        logic [7:0] cv;
        logic [7:0] cvm;
        logic [7:0] fl;
        logic [7:0] en;
        int         per;
        int         n;
        time        tp;
        per = exp_period(sel, p);
        fl = 8'h01 << (t ? DIT_SECOND_FLAG_BIT : DIT_FIRST_FLAG_BIT);
        en = 8'h01 << (t ? DIT_SECOND_EN_BIT : DIT_FIRST_EN_BIT);
        cv = (8'(sel) << (t ? DIT_SECOND_SEL_LSB : DIT_FIRST_SEL_LSB)) | en;
        cvm = cv & ~en;
        wr(DIT_CTRL_IDX, 32'(cv));
        wr(t ? DIT_SECOND_PERIOD_IDX : DIT_FIRST_PERIOD_IDX, 32'(p));
        tp = t_take;
        wr(DIT_CTRL_IDX, 32'(cv));
        rd_check("idle counter", t ? DIT_FIRST_COUNT_IDX : DIT_SECOND_COUNT_IDX,
                 32'h0, DIT_RESP_OKAY);
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n > 2000) give_up();
        end while (timer_irq !== 1'b1);
        check("cycles to flag", 32'(per), 32'(($time - 20 - tp) / 40));
        // clear lands on the next overflow edge
        repeat (per - 1) @(posedge clk);
        wr(DIT_CTRL_IDX, 32'(cv));
        rd_check("flag kept", DIT_CTRL_IDX, 32'(cv | fl),
                 DIT_RESP_OKAY);
        wr(DIT_CTRL_IDX, 32'(cvm));
        @(negedge clk);
        check("irq cleared", 32'h0, 32'(timer_irq));
        repeat (2 * per) @(negedge clk);
        check("irq masked", 32'h0, 32'(timer_irq));
        @(posedge clk);
        rd_check("flag again", DIT_CTRL_IDX, 32'(cvm | fl),
                 DIT_RESP_OKAY);
        wr(DIT_CTRL_IDX, 32'h0);
        rd_check("stopped counter",
                 t ? DIT_SECOND_COUNT_IDX : DIT_FIRST_COUNT_IDX,
                 32'h0, DIT_RESP_OKAY);
    endtask

    initial begin
        int          i;
        int          t;
        int          s;
        logic [31:0] d1;
        logic [31:0] d2;
        logic [1:0]  r;
        rst_n = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = '0;
        araddr = '0;
        wdata = 32'h0;
        wstrb = 4'h0;
        errors = 0;
        total_checks = 0;
        void'($urandom(32));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        rd_check("control reset", DIT_CTRL_IDX, 32'(DIT_CTRL_RST),
                 DIT_RESP_OKAY);
        rd_check("period1 reset", DIT_FIRST_PERIOD_IDX,
                 32'(DIT_PERIOD_RST), DIT_RESP_OKAY);
        rd_check("period2 reset", DIT_SECOND_PERIOD_IDX,
                 32'(DIT_PERIOD_RST), DIT_RESP_OKAY);
        rd_check("unmapped read", 16'hfe3d, 32'h0, DIT_RESP_SLVERR);
        bus_write(16'hfe3d, 32'h5a, 4'hf, r);
        check("unmapped write", 32'(DIT_RESP_SLVERR), 32'(r));
        for (i = 0; i < 4; i++) begin
            d1 = $urandom();
            d2 = $urandom();
            wr(DIT_FIRST_PERIOD_IDX, d1);
            wr(DIT_SECOND_PERIOD_IDX, d2);
            rd_check("period1", DIT_FIRST_PERIOD_IDX, {24'h0, d1[7:0]},
                     DIT_RESP_OKAY);
            rd_check("period2", DIT_SECOND_PERIOD_IDX, {24'h0, d2[7:0]},
                     DIT_RESP_OKAY);
        end
        bus_write(DIT_FIRST_PERIOD_IDX, ~d1, 4'h0, r);
        check("no strobe resp", 32'(DIT_RESP_OKAY), 32'(r));
        rd_check("no strobe", DIT_FIRST_PERIOD_IDX, {24'h0, d1[7:0]},
                 DIT_RESP_OKAY);
        wr(DIT_FIRST_COUNT_IDX, 32'hff);
        rd_check("counter write", DIT_FIRST_COUNT_IDX, 32'h0,
                 DIT_RESP_OKAY);
        for (t = 0; t < 2; t++) begin
            for (s = 1; s < 4; s++) begin
                run_timer(t, s, $urandom_range(1, 3));
            end
        end
        close_out();
    end
endmodule
